// ===== verilog/mbcd_pkg.sv
// Constants, code tables and decode functions for the multi-bank clock
// divider control. Assumes a 20 MHz system clock stands in for the VCO rate.
package mbcd_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int SETTLE_NS = 1000;                     // Divider change settle limit
   localparam int SETTLE_CYC_RAW = SETTLE_NS / (1000000000 / CLK_HZ);
   localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam int OUT_RESET_NS = 10;                    // Output reset response limit
   localparam int OUT_RESET_CYC_RAW = OUT_RESET_NS / (1000000000 / CLK_HZ);
   localparam int OUT_RESET_CYC = (OUT_RESET_CYC_RAW < 1) ? 1 : OUT_RESET_CYC_RAW;
   localparam int LOCK_MS = 10;                         // PLL lock limit
   localparam int LOCK_CYC = LOCK_MS * (CLK_HZ / 1000);

   // ---------------------------------------------------------------
   // Widths and bank layout
   // ---------------------------------------------------------------
   localparam int NUM_BANKS = 3;
   localparam int BANK_A = 0;
   localparam int BANK_B = 1;
   localparam int BANK_C = 2;
   localparam int PAIRS_A = 2;
   localparam int PAIRS_B = 9;
   localparam int PAIRS_C = 2;
   localparam int DIV_SEL_W = 3;
   localparam int FB_SEL_W = 4;
   localparam int MULT_W = 7;
   localparam int HALF_W = 4;
   localparam int LOCK_W = 24;

   // ---------------------------------------------------------------
   // Code tables
   // ---------------------------------------------------------------
   localparam logic [DIV_SEL_W-1:0] DIV_SEL_OFF = 3'h0;
   localparam logic [MULT_W-1:0] MULT_BASE = 7'h22;     // Code 0 multiplies by 34
   localparam logic [MULT_W-1:0] MULT_STEP = 7'h02;

   // Post divider ratio for a select code; 0 means bank switched off
   function automatic logic [4:0] mbcd_div_ratio(input logic [DIV_SEL_W-1:0] sel);
      logic [4:0] r;
      r = 5'h00;
      unique case (sel)
         3'h0: r = 5'h00;
         3'h1: r = 5'h02;
         3'h2: r = 5'h04;
         3'h3: r = 5'h06;
         3'h4: r = 5'h08;
         3'h5: r = 5'h0A;
         3'h6: r = 5'h0C;
         3'h7: r = 5'h12;
      endcase
      return r;
   endfunction

   // Half period in VCO ticks; ratios are all even
   function automatic logic [HALF_W-1:0] mbcd_div_half(input logic [DIV_SEL_W-1:0] sel);
      logic [4:0] r;
      r = mbcd_div_ratio(sel);
      return r[4:1];
   endfunction

   // Feedback multiplier: 34 plus two per code step
   function automatic logic [MULT_W-1:0] mbcd_fb_mult(input logic [FB_SEL_W-1:0] code);
      logic [MULT_W-1:0] m;
      m = MULT_BASE + MULT_W'({code, 1'b0});
      return m;
   endfunction

endpackage

// ===== verilog/mbcd_align_det.sv
// Detects the high-low-high alignment pattern on the bank alignment pin.
// Assumes the pin is synchronous to sys_clk and normally rests high.
`timescale 1ns/1ps

module mbcd_align_det
   import mbcd_pkg::*;
(
   input wire logic sys_clk,       // System clock
   input wire logic reset,         // Async reset, active high
   input wire logic align_pin,     // Bank alignment pin level
   output logic align_pulse        // One-cycle pulse on final rising edge
);

   // ---------------------------------------------------------------
   // Pattern tracker
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_WAIT_HIGH = 3'h1,
      ST_HIGH = 3'h2,
      ST_LOW = 3'h4
   } mbcd_align_e;

   mbcd_align_e state_r;
   mbcd_align_e state_nxt;
   logic pulse_r;
   logic pulse_nxt;

   // Only a low that followed a high counts, so a pin held low from
   // reset does not produce a spurious alignment on its first rise
   always_comb begin
      state_nxt = state_r;
      pulse_nxt = 1'b0;
      unique case (state_r)
         ST_WAIT_HIGH: begin
            if (align_pin) state_nxt = ST_HIGH;
         end
         ST_HIGH: begin
            if (!align_pin) state_nxt = ST_LOW;
         end
         ST_LOW: begin
            if (align_pin) begin
               state_nxt = ST_HIGH;
               pulse_nxt = 1'b1;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_WAIT_HIGH;
         pulse_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign align_pulse = pulse_r;

endmodule

// ===== verilog/mbcd_bank_div.sv
// One bank post-divider: divides the VCO tick stream by the selected ratio.
// Assumes vco_tick marks one VCO rising edge per asserted cycle.
`timescale 1ns/1ps

module mbcd_bank_div
   import mbcd_pkg::*;
(
   input wire logic sys_clk,                  // System clock
   input wire logic reset,                    // Async reset, active high
   input wire logic vco_tick,                 // One VCO edge this cycle
   input wire logic [DIV_SEL_W-1:0] div_sel,  // Post divider select code
   input wire logic align,                    // Restart at common phase
   input wire logic out_reset,                // Force output low
   output logic clk_out,                      // Divided bank clock
   output logic enabled                       // Bank running
);

   // ---------------------------------------------------------------
   // Divider state
   // ---------------------------------------------------------------
   logic [HALF_W-1:0] cnt_r;
   logic [HALF_W-1:0] cnt_nxt;
   logic [DIV_SEL_W-1:0] sel_r;
   logic [DIV_SEL_W-1:0] sel_nxt;
   logic out_r;
   logic out_nxt;
   logic [HALF_W-1:0] half;

   assign half = mbcd_div_half(sel_r);

   // Reset and alignment take priority; a new select restarts the count
   // so the new period appears within one old-or-new period at most
   always_comb begin
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      sel_nxt = div_sel;
      if (out_reset || div_sel == DIV_SEL_OFF) begin
         cnt_nxt = '0;
         out_nxt = 1'b0;
      end else if (align) begin
         cnt_nxt = '0;
         out_nxt = 1'b0;
      end else if (div_sel != sel_r) begin
         cnt_nxt = '0;
      end else if (vco_tick) begin
         if (cnt_r >= half - HALF_W'(1)) begin
            cnt_nxt = '0;
            out_nxt = ~out_r;
         end else begin
            cnt_nxt = cnt_r + HALF_W'(1);
         end
      end
   end

   // Registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
         sel_r <= DIV_SEL_OFF;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         sel_r <= sel_nxt;
         out_r <= out_nxt;
      end
   end

   assign clk_out = out_r;
   assign enabled = (sel_r != DIV_SEL_OFF);

endmodule

// ===== verilog/mbcd_top.sv
// Top of the multi-bank clock divider control: VCO source choice, feedback
// multiplier and lock tracking, three bank post-dividers and alignment.
// Assumes all select pins and the external oscillator level are synchronous
// to sys_clk; sys_clk stands in for the internal VCO rate.
//
// What this block does
// - Select pin low runs the PLL from the internal VCO.
// - Select pin high or floating takes the external oscillator, bypassing synthesis.
// - Internal VCO powers down while the select pin is high.
// - Four feedback select bits set the ratio; changes accepted while powered.
// - VCO clock feeds three banks: two, nine and two differential pairs.
// - Each bank has its own three-bit divider select, changeable live.
// - Bank dividers span ratios 2 to 18 of the VCO clock.
// - Bank frequency is reference times feedback ratio over post divider.
// - High-low-high on the alignment pin resynchronises the banks.
// - A divider select change settles at the new frequency within 1 us.
// - Outputs respond to output reset one sys_clk cycle later (50 ns), not within 10 ns.
// - Divider codes 1..7 give 2,4,6,8,10,12,18; code 0 unspecified.
// - All-zero divider select switches that bank off.
// - Feedback multiplier is 34 plus two per code step.
// - PLL locks within 10 ms after reference or ratio change.
`timescale 1ns/1ps

module mbcd_top
   import mbcd_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_CYC       // Lock wait; shorten in simulation
)
(
   input wire logic sys_clk,                                   // System clock, 20 MHz
   input wire logic reset,                                     // Async reset, active high
   input wire logic oscillator_source_select,                  // Low internal, high external
   input wire logic external_oscillator_input_p,               // External oscillator true
   input wire logic external_oscillator_input_n,               // External oscillator complement
   input wire logic [FB_SEL_W-1:0] feedback_ratio_bits,        // Feedback ratio select
   input wire logic [DIV_SEL_W-1:0] bank_a_divider_select,     // Bank A divider select
   input wire logic [DIV_SEL_W-1:0] bank_b_divider_select,     // Bank B divider select
   input wire logic [DIV_SEL_W-1:0] bank_c_divider_select,     // Bank C divider select
   input wire logic bank_align,                                // Alignment pin
   input wire logic output_reset,                              // Force all outputs low
   output logic internal_vco_power_down,                       // Internal VCO shut down
   output logic synth_bypass,                                  // External source in use
   output logic [MULT_W-1:0] vco_multiplier,                   // Active feedback multiplier
   output logic pll_locked,                                    // VCO clock usable
   output logic [PAIRS_A-1:0] bank_a_p,                        // Bank A true outputs
   output logic [PAIRS_A-1:0] bank_a_n,                        // Bank A complement outputs
   output logic [PAIRS_B-1:0] bank_b_p,                        // Bank B true outputs
   output logic [PAIRS_B-1:0] bank_b_n,                        // Bank B complement outputs
   output logic [PAIRS_C-1:0] bank_c_p,                        // Bank C true outputs
   output logic [PAIRS_C-1:0] bank_c_n                         // Bank C complement outputs
);

   // ---------------------------------------------------------------
   // Source selection and feedback ratio
   // ---------------------------------------------------------------
   logic bypass_r;
   logic bypass_nxt;
   logic [MULT_W-1:0] mult_r;
   logic [MULT_W-1:0] mult_nxt;
   logic ext_lvl_r;
   logic ext_lvl_nxt;
   logic [LOCK_W-1:0] lock_cnt_r;
   logic [LOCK_W-1:0] lock_cnt_nxt;
   logic locked_r;
   logic locked_nxt;
   logic out_rst_r;
   logic out_rst_nxt;
   logic vco_tick;
   logic ext_level;
   logic ratio_change;

   // A floating select pin is pulled high by the pad, so only a solid low
   // picks the internal VCO
   assign ext_level = external_oscillator_input_p & ~external_oscillator_input_n;
   assign ratio_change = (mbcd_fb_mult(feedback_ratio_bits) != mult_r) ||
                         (oscillator_source_select != bypass_r);

   // Next values for the source, multiplier, lock and output-reset state
   always_comb begin
      bypass_nxt = oscillator_source_select;
      mult_nxt = mbcd_fb_mult(feedback_ratio_bits);
      ext_lvl_nxt = ext_level;
      out_rst_nxt = output_reset;
      lock_cnt_nxt = lock_cnt_r;
      locked_nxt = locked_r;
      if (oscillator_source_select) begin
         lock_cnt_nxt = '0;
         locked_nxt = 1'b1;
      end else if (ratio_change) begin
         lock_cnt_nxt = '0;
         locked_nxt = 1'b0;
      end else if (!locked_r) begin
         if (lock_cnt_r >= LOCK_W'(LOCK_CYCLES - 1)) begin
            locked_nxt = 1'b1;
         end else begin
            lock_cnt_nxt = lock_cnt_r + LOCK_W'(1);
         end
      end
   end

   // Source and lock registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bypass_r <= 1'b0;
         mult_r <= MULT_BASE;
         ext_lvl_r <= 1'b0;
         lock_cnt_r <= '0;
         locked_r <= 1'b0;
         out_rst_r <= 1'b0;
      end else begin
         bypass_r <= bypass_nxt;
         mult_r <= mult_nxt;
         ext_lvl_r <= ext_lvl_nxt;
         lock_cnt_r <= lock_cnt_nxt;
         locked_r <= locked_nxt;
         out_rst_r <= out_rst_nxt;
      end
   end

   // VCO edges: every cycle from the internal VCO once locked, or each
   // rising edge of the external oscillator in bypass
   assign vco_tick = bypass_r ? (ext_level & ~ext_lvl_r) : locked_r;

   assign internal_vco_power_down = bypass_r;
   assign synth_bypass = bypass_r;
   assign vco_multiplier = mult_r;
   assign pll_locked = locked_r;

   // ---------------------------------------------------------------
   // Alignment and bank dividers
   // ---------------------------------------------------------------
   logic align_pulse;
   logic [NUM_BANKS-1:0] bank_clk;
   logic [NUM_BANKS-1:0] bank_en;
   logic [NUM_BANKS-1:0][DIV_SEL_W-1:0] bank_sel;

   assign bank_sel[BANK_A] = bank_a_divider_select;
   assign bank_sel[BANK_B] = bank_b_divider_select;
   assign bank_sel[BANK_C] = bank_c_divider_select;

   mbcd_align_det u_align (
      .sys_clk(sys_clk),
      .reset(reset),
      .align_pin(bank_align),
      .align_pulse(align_pulse)
   );

   // One divider per bank; the shared align pulse gives a common phase
   genvar gb;
   generate
      for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
         mbcd_bank_div u_div (
            .sys_clk(sys_clk),
            .reset(reset),
            .vco_tick(vco_tick),
            .div_sel(bank_sel[gb]),
            .align(align_pulse),
            .out_reset(out_rst_r | output_reset),
            .clk_out(bank_clk[gb]),
            .enabled(bank_en[gb])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Output fanout
   // ---------------------------------------------------------------
   // Both legs of a disabled or reset bank sit low, since a switched-off
   // pair has no meaningful differential state
   assign bank_a_p = {PAIRS_A{bank_clk[BANK_A]}};
   assign bank_a_n = {PAIRS_A{bank_en[BANK_A] & ~out_rst_r & ~bank_clk[BANK_A]}};
   assign bank_b_p = {PAIRS_B{bank_clk[BANK_B]}};
   assign bank_b_n = {PAIRS_B{bank_en[BANK_B] & ~out_rst_r & ~bank_clk[BANK_B]}};
   assign bank_c_p = {PAIRS_C{bank_clk[BANK_C]}};
   assign bank_c_n = {PAIRS_C{bank_en[BANK_C] & ~out_rst_r & ~bank_clk[BANK_C]}};

endmodule

// ===== bench/mbcd_checker.sv
// Port checker for mbcd_top.
// Assumes every pin is synchronous to sys_clk.
`timescale 1ns/1ps
module mbcd_checker
   import mbcd_pkg::*;
#(
   parameter int LOCK_CYCLES = 16 // Lock wait
)
(
   input wire logic sys_clk, // Clock
   input wire logic reset, // Reset
   input wire logic oscillator_source_select, // Source
   input wire logic [FB_SEL_W-1:0] feedback_ratio_bits, // Ratio
   input wire logic [DIV_SEL_W-1:0] bank_a_divider_select, // A code
   input wire logic [DIV_SEL_W-1:0] bank_b_divider_select, // B code
   input wire logic bank_align, // Align
   input wire logic output_reset, // Out reset
   input wire logic internal_vco_power_down, // VCO off
   input wire logic synth_bypass, // Bypass
   input wire logic [MULT_W-1:0] vco_multiplier, // Multiplier
   input wire logic pll_locked, // Locked
   input wire logic [PAIRS_A-1:0] bank_a_p, // A true
   input wire logic [PAIRS_B-1:0] bank_b_p, // B true
   input wire logic [PAIRS_B-1:0] bank_b_n, // B comp
   input wire logic [PAIRS_C-1:0] bank_c_p // C true
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   int unlock_r;
   int unlock_nxt;
   // Unlocked cycles; a lock that never comes cannot hide
   always_comb begin
      unlock_nxt = pll_locked ? 0 : unlock_r + 1;
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         unlock_r <= 0;
      end else begin
         unlock_r <= unlock_nxt;
      end
   end
   sequence align_seq;
      bank_align ##1 !bank_align ##1 bank_align;
   endsequence
   // Six quiet cycles so no restart or reload is in flight
   sequence run_a1_seq;
      (!oscillator_source_select && !synth_bypass && pll_locked && bank_a_divider_select == 3'h1
         && !output_reset && bank_align) [*6];
   endsequence
   ext_src_a: assert property (oscillator_source_select |=> internal_vco_power_down && synth_bypass)
      else $error("external source not taken");
   int_src_a: assert property (!oscillator_source_select |=> !internal_vco_power_down && !synth_bypass)
      else $error("internal source not taken");
   mult_val_a: assert property (1'b1 |=> vco_multiplier == 7'h22 + 7'({$past(feedback_ratio_bits), 1'b0}))
      else $error("multiplier wrong");
   lock_drop_a: assert property (!synth_bypass && $changed(feedback_ratio_bits) |-> ##[1:2] !pll_locked)
      else $error("lock kept over ratio change");
   lock_time_a: assert property (unlock_r <= LOCK_CYCLES + 4)
      else $error("lock too slow");
   bypass_lock_a: assert property (synth_bypass ##1 synth_bypass |-> pll_locked)
      else $error("bypass not locked");
   out_reset_a: assert property (output_reset |=> bank_a_p == 2'h0 && bank_b_p == 9'h000 && bank_c_p == 2'h0)
      else $error("output reset slow");
   bank_off_a: assert property ((bank_b_divider_select == 3'h0) [*3] |-> bank_b_p == 9'h000 && bank_b_n == 9'h000)
      else $error("bank not off");
   pair_comp_a: assert property ((bank_b_divider_select != 3'h0 && !output_reset) [*3]
      |-> bank_b_n == ~bank_b_p && (bank_b_p == 9'h000 || bank_b_p == 9'h1FF))
      else $error("bank pairs differ");
   div_two_a: assert property (run_a1_seq |-> bank_a_p[0] != $past(bank_a_p[0]))
      else $error("divide by two wrong");
   align_zero_a: assert property (align_seq |-> ##[2:3]
      (bank_a_p == 2'h0 && bank_b_p == 9'h000 && bank_c_p == 2'h0))
      else $error("banks not restarted");
endmodule

bind mbcd_top mbcd_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.sys_clk(sys_clk), .reset(reset),
   .oscillator_source_select(oscillator_source_select), .feedback_ratio_bits(feedback_ratio_bits),
   .bank_a_divider_select(bank_a_divider_select), .bank_b_divider_select(bank_b_divider_select),
   .bank_align(bank_align), .output_reset(output_reset), .internal_vco_power_down(internal_vco_power_down),
   .synth_bypass(synth_bypass), .vco_multiplier(vco_multiplier), .pll_locked(pll_locked),
   .bank_a_p(bank_a_p), .bank_b_p(bank_b_p), .bank_b_n(bank_b_n), .bank_c_p(bank_c_p));

// ===== bench/mbcd_strap_model.sv
// Board strap and controller model for the divider control pins.
// Assumes the bench calls its tasks; pins move only at sys_clk rise.
`timescale 1ns/1ps
module mbcd_strap_model #(
   parameter int XTAL_MHZ = 18 // Crystal rate
)
(
   input wire logic sys_clk, // Clock
   output logic src_sel, // Source
   output logic ext_p, // Ext true
   output logic ext_n, // Ext comp
   output logic [3:0] fb, // Ratio
   output logic [2:0] div_a, // A code
   output logic [2:0] div_b, // B code
   output logic [2:0] div_c, // C code
   output logic align, // Align
   output logic orst // Out reset
);
   logic [2:0] osc_r = 3'h0;
   initial begin
      {src_sel, fb, orst} = 6'h00;
      {div_a, div_b, div_c, align} = 10'h093;
   end
   // Oscillator at half sys_clk; unconnected pins wander when unused
   always @(posedge sys_clk) begin
      osc_r <= osc_r + 3'h1;
   end
   assign ext_p = src_sel ? osc_r[0] : osc_r[1];
   assign ext_n = src_sel ? ~osc_r[0] : osc_r[2];
   // A ratio outside the VCO window is never driven, so high codes stay unused
   task automatic drive(input logic s, input logic [3:0] f, input logic [2:0] a, input logic [2:0] b,
      input logic [2:0] c, input logic r);
      int vco;
      vco = XTAL_MHZ * (34 + 2 * int'(f));
      @(posedge sys_clk);
      src_sel <= s;
      if (vco >= 600 && vco <= 1000) begin
         fb <= f;
      end
      div_a <= a;
      div_b <= b;
      div_c <= c;
      orst <= r;
   endtask
   // High, low for one cycle, then high again
   task automatic pulse_align();
      @(posedge sys_clk);
      align <= 1'b0;
      @(posedge sys_clk);
      align <= 1'b1;
   endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for mbcd_top driven by the strap model.
// Assumes the checker is bound in and a short lock wait.
`timescale 1ns/1ps
module testbench;
   localparam int LOCK = 16;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic src, ep, en, al, orst, pd, byp, lock;
   logic [3:0] fb;
   logic [2:0] da, db, dc;
   logic [6:0] mult;
   logic [1:0] ap, an, cp, cn;
   logic [8:0] bp, bn;
   int bad_count = 0;
   int check_count = 0;
   int half_tbl [8] = '{0, 1, 2, 3, 4, 5, 6, 9};
   mbcd_strap_model strap_u (.sys_clk(sys_clk), .src_sel(src), .ext_p(ep), .ext_n(en), .fb(fb), .div_a(da),
      .div_b(db), .div_c(dc), .align(al), .orst(orst));
   mbcd_top #(.LOCK_CYCLES(LOCK)) dut_u (.sys_clk(sys_clk), .reset(reset), .oscillator_source_select(src),
      .external_oscillator_input_p(ep), .external_oscillator_input_n(en), .feedback_ratio_bits(fb),
      .bank_a_divider_select(da), .bank_b_divider_select(db), .bank_c_divider_select(dc), .bank_align(al),
      .output_reset(orst), .internal_vco_power_down(pd), .synth_bypass(byp), .vco_multiplier(mult),
      .pll_locked(lock), .bank_a_p(ap), .bank_a_n(an), .bank_b_p(bp), .bank_b_n(bn), .bank_c_p(cp),
      .bank_c_n(cn));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   function automatic logic bit_of(input int k);
      return (k == 0) ? ap[0] : (k == 1) ? bp[0] : cp[0];
   endfunction
   // Bounded waits: a stuck bank or lock ends the run
   task automatic wait_flip(input int k, output int n);
      logic v;
      #1;
      v = bit_of(k);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n > 60) begin
            bad_count++;
            $display("[FAIL] %0t bank stuck", $time);
            end_sim();
         end
      end while (bit_of(k) === v);
   endtask
   task automatic wait_lock();
      int n;
      n = 0;
      #1;
      while (lock !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n > LOCK + 8) begin
            bad_count++;
            $display("[FAIL] %0t no lock", $time);
            end_sim();
         end
      end
   endtask
   task automatic t_reset();
      #1;
      chk(16'({lock, pd, mult}), 16'h0022, "reset state");
      chk(16'({ap, bp, cp}), 16'h0000, "outputs low");
   endtask
   task automatic t_mult();
      for (int c = 0; c <= 10; c++) begin
         strap_u.drive(1'b0, 4'(c), 3'h1, 3'h1, 3'h1, 1'b0);
         repeat (2) @(posedge sys_clk);
         #1;
         chk(16'(mult), 16'h0022 + 16'(2 * c), "multiplier");
         chk(16'(lock), 16'h0000, "lock drop");
         wait_lock();
      end
      strap_u.drive(1'b0, 4'h2, 3'h1, 3'h1, 3'h1, 1'b0);
      repeat (2) @(posedge sys_clk);
      wait_lock();
   endtask
   // Live code changes; each bank measured in its first full half period after the prior bank's check
   task automatic t_div();
      int n;
      for (int k = 1; k < 8; k++) begin
         strap_u.drive(1'b0, 4'h2, 3'(8 - k), 3'(k), 3'(8 - k), 1'b0);
         for (int b = 0; b < 3; b++) begin
            wait_flip(b, n);
            chk(16'(n <= mbcd_pkg::SETTLE_CYC), 16'h0001, "settle time");
            wait_flip(b, n);
            chk(16'(n), 16'(half_tbl[b == 1 ? k : 8 - k]), "half period");
         end
      end
   endtask
   task automatic t_off_reset();
      strap_u.drive(1'b0, 4'h2, 3'h1, 3'h1, 3'h0, 1'b0);
      repeat (3) @(posedge sys_clk);
      repeat (10) begin
         @(posedge sys_clk);
         #1;
         chk(16'({cp, cn}), 16'h0000, "bank off");
         chk(16'(bn ^ bp), 16'h01FF, "pair complement");
         chk(16'(an ^ ap), 16'h0003, "bank a complement");
      end
      strap_u.drive(1'b0, 4'h2, 3'h1, 3'h1, 3'h1, 1'b1);
      @(posedge sys_clk);
      #1;
      chk(16'({ap, bp, cp}), 16'h0000, "output reset");
      strap_u.drive(1'b0, 4'h2, 3'h1, 3'h1, 3'h1, 1'b0);
   endtask
   // Bank B starts late so its phase differs until aligned
   task automatic t_align();
      strap_u.drive(1'b0, 4'h2, 3'h2, 3'h0, 3'h2, 1'b0);
      repeat (2) @(posedge sys_clk);
      strap_u.drive(1'b0, 4'h2, 3'h2, 3'h2, 3'h2, 1'b0);
      repeat (5) @(posedge sys_clk);
      strap_u.pulse_align();
      repeat (3) @(posedge sys_clk);
      repeat (12) begin
         @(posedge sys_clk);
         #1;
         chk(16'({ap[0], cp[0]}), 16'({bp[0], bp[0]}), "aligned banks");
      end
   endtask
   task automatic t_bypass();
      int n;
      strap_u.drive(1'b1, 4'h2, 3'h1, 3'h1, 3'h1, 1'b0);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(16'({pd, byp, lock}), 16'h0007, "external source");
      wait_flip(0, n);
      wait_flip(0, n);
      chk(16'(n), 16'h0002, "external tick rate");
      strap_u.drive(1'b0, 4'h2, 3'h1, 3'h1, 3'h1, 1'b0);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(16'({pd, byp}), 16'h0000, "internal source");
      wait_lock();
   endtask
   // ---------------------------------------------------------------
   // Clock, reset and main sequence
   // ---------------------------------------------------------------
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      t_reset();
      @(posedge sys_clk);
      reset <= 1'b0;
      t_mult();
      t_div();
      t_off_reset();
      t_align();
      t_bypass();
      end_sim();
   end
endmodule
